// File: src/dma_flag_config.sv
/*
 * Register block of an eight-channel DMA controller: flag status and
 * write-one flag clear, per-channel configuration and unit counts,
 * interrupt mask, and priority choice among pending channels.
 * Byte map of the register window:
 *   0x00      flag status, four bits per channel (summary, complete, half, error)
 *   0x04      flag clear, same layout, write-only, reads zero
 *   0x08-0x24 channel configuration, one word per channel
 *   0x28-0x44 unit count; a write loads it while the channel is disabled, a read returns what remains
 *   0x48      interrupt mask, same layout as the flag status
 * Every transfer is a whole word; writes complete without wait states and
 * reads take one wait state.
 * Assumes an AHB-Lite master on hclk and a transfer engine on hclk that
 * reports moved units and bus errors per channel and follows the grant.
 */
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "dma_flags_defs.svh"

module dma_flag_config (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] channel_request,
  input wire logic [7:0] unit_done,
  input wire logic [7:0] bus_error,
  output logic [7:0] grant,
  output logic grant_valid,
  output logic [1:0] memory_side_width,
  output logic memory_side_is_source,
  output logic mem_to_mem_enable,
  output logic width_reserved,
  output logic irq
);
  import dma_flags_pkg::*;

  ctrl_state_type state;
  ctrl_state_type next_state;

  logic [31:0] flag_word;
  logic [7:0] pending;
  logic [15:0] priority_levels;
  logic [7:0] arb_grant;
  logic arb_valid;
  logic [7:0] count_load;
  logic [15:0] remaining [8];
  logic [7:0] enable;
  logic [31:0] clear_word;
  logic take_request;
  logic write_cycle;
  logic [31:0] read_mux;
  logic [1:0] sel_width;
  logic sel_dir;
  logic sel_m2m;
  logic [7:0] config_hit;
  logic [7:0] count_hit;
  logic addr_is_status;
  logic addr_is_clear;
  logic addr_is_mask;
  logic mask_write;
  logic clear_write;
  logic [1:0] attr_width [8];
  logic [7:0] attr_dir;
  logic [7:0] attr_m2m;

  // ****************************************
  // per-channel flag and counter slices
  // ****************************************
  genvar ch;
  generate
    for (ch = 0; ch < 8; ch++) begin : g_channel
      assign enable[ch] = state.config_reg[ch][`ENABLE_BIT];
      assign priority_levels[2*ch +: 2] = state.config_reg[ch][`PRIO_MSB:`PRIO_LSB];
      // a memory-to-memory channel needs no peripheral request
      assign pending[ch] = enable[ch] && (remaining[ch] != 16'h0000)
        && (channel_request[ch] || state.config_reg[ch][`MEM_TO_MEM_BIT]);
      assign config_hit[ch] = (state.addr == `CONFIG_BASE_ADDR + 8'(4 * ch));
      assign count_hit[ch] = (state.addr == `COUNT_BASE_ADDR + 8'(4 * ch));
      // a running channel keeps its count; software disables it before reloading
      assign count_load[ch] = write_cycle && !enable[ch] && count_hit[ch];
      // slices of channels that are not granted stay zero
      assign attr_width[ch] = arb_grant[ch]
        ? state.config_reg[ch][`WIDTH_MSB:`WIDTH_LSB] : 2'h0;
      assign attr_dir[ch] = arb_grant[ch] && state.config_reg[ch][`DIR_BIT];
      assign attr_m2m[ch] = arb_grant[ch] && state.config_reg[ch][`MEM_TO_MEM_BIT];

      dma_channel_status u_status (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(enable[ch]),
        .count_load(count_load[ch]),
        .count_value(hwdata[15:0]),
        .unit_done(unit_done[ch]),
        .bus_error(bus_error[ch]),
        .clear(clear_word[`GROUP_WIDTH*ch +: `GROUP_WIDTH]),
        .flags(flag_word[`GROUP_WIDTH*ch +: `GROUP_WIDTH]),
        .remaining(remaining[ch])
      );
    end
  endgenerate

  dma_priority_arbiter u_arbiter (
    .pending(pending),
    .priority_levels(priority_levels),
    .grant(arb_grant),
    .grant_valid(arb_valid)
  );

  // ****************************************
  // bus decode
  // ****************************************
  assign take_request = hsel && hready && htrans[1];
  assign write_cycle = (state.phase == bus_write);
  assign addr_is_status = (state.addr == `FLAG_STATUS_ADDR);
  assign addr_is_clear = (state.addr == `FLAG_CLEAR_ADDR);
  assign addr_is_mask = (state.addr == `IRQ_MASK_ADDR);
  assign mask_write = write_cycle && addr_is_mask;
  assign clear_write = write_cycle && addr_is_clear;
  // only a write to the clear word produces clear pulses; ones clear, zeros do nothing
  assign clear_word = clear_write ? hwdata : 32'h00000000;

  // ****************************************
  // read data selection
  // ****************************************
  // the clear word and unmapped offsets fall through and read as zero
  always_comb begin
    read_mux = 32'h00000000;
    if (addr_is_status) begin
      read_mux = flag_word;
    end
    if (addr_is_mask) begin
      read_mux = state.irq_mask;
    end
    for (int i = 0; i < 8; i++) begin
      if (config_hit[i]) begin
        read_mux = {17'h00000, state.config_reg[i]};
      end
      if (count_hit[i]) begin
        read_mux = {16'h0000, remaining[i]};
      end
    end
  end

  // ****************************************
  // granted channel attributes
  // ****************************************
  // the grant is one-hot and idle slices are zero, so or-ing them picks the winner
  always_comb begin
    sel_width = 2'h0;
    sel_dir = |attr_dir;
    sel_m2m = |attr_m2m;
    for (int i = 0; i < 8; i++) begin
      sel_width = sel_width | attr_width[i];
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state = state;
    unique case (state.phase)
      bus_idle, bus_write, bus_read_done: begin
        if (take_request) begin
          next_state.addr = {haddr[7:2], 2'b00};
          next_state.phase = hwrite ? bus_write : bus_read_wait;
        end else begin
          next_state.phase = bus_idle;
        end
      end
      bus_read_wait: begin
        // one wait state so the read sees any write that just landed
        next_state.read_data = read_mux;
        next_state.phase = bus_read_done;
      end
    endcase
    // register writes land at the end of the data phase
    if (mask_write) begin
      next_state.irq_mask = hwdata;
    end
    for (int i = 0; i < 8; i++) begin
      if (write_cycle && config_hit[i]) begin
        // bits without a function are dropped so they read back as zero
        next_state.config_reg[i] = hwdata[14:0] & `CONFIG_WRITE_MASK;
      end
    end
    // granted channel and its attributes are registered on the same edge
    next_state.grant = arb_grant;
    next_state.grant_valid = arb_valid;
    next_state.width = sel_width;
    // same dir role in memory-to-memory and peripheral use
    next_state.width_is_source = sel_dir;
    next_state.mem_to_mem = sel_m2m;
    next_state.width_reserved = arb_valid && (sel_width == `WIDTH_RESERVED_CODE);
    next_state.irq = |(flag_word & state.irq_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '{
        phase: bus_idle,
        addr: 8'h00,
        config_reg: {8{`CONFIG_RESET}},
        irq_mask: `MASK_RESET,
        read_data: `READ_RESET,
        grant: 8'h00,
        grant_valid: 1'b0,
        width: 2'h0,
        width_is_source: 1'b0,
        mem_to_mem: 1'b0,
        width_reserved: 1'b0,
        irq: 1'b0
      };
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign hreadyout = (state.phase != bus_read_wait);
  assign hresp = 1'b0;
  assign hrdata = state.read_data;
  assign grant = state.grant;
  assign grant_valid = state.grant_valid;
  assign memory_side_width = state.width;
  assign memory_side_is_source = state.width_is_source;
  assign mem_to_mem_enable = state.mem_to_mem;
  assign width_reserved = state.width_reserved;
  assign irq = state.irq;

endmodule

// File: src/dma_flags_defs.svh
/*
 * Constants for the DMA flag and channel configuration block: byte offsets,
 * field positions, reset values and widths.
 * Assumes inclusion by bare name from the design files of this block only.
 */
`ifndef DMA_FLAGS_DEFS_SVH
`define DMA_FLAGS_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define FLAG_STATUS_ADDR 8'h00
`define FLAG_CLEAR_ADDR 8'h04
`define CONFIG_BASE_ADDR 8'h08
`define COUNT_BASE_ADDR 8'h28
`define IRQ_MASK_ADDR 8'h48
`define ADDR_END 8'h4c

// ****************************************
// flag group layout, four bits per channel
// ****************************************
`define GROUP_WIDTH 4
`define ALL_FLAGS_BIT 0
`define COMPLETE_BIT 1
`define HALF_BIT 2
`define ERROR_BIT 3

// ****************************************
// channel configuration fields
// ****************************************
`define ENABLE_BIT 0
`define DIR_BIT 4
`define WIDTH_LSB 10
`define WIDTH_MSB 11
`define PRIO_LSB 12
`define PRIO_MSB 13
`define MEM_TO_MEM_BIT 14
`define CONFIG_WRITE_MASK 15'h7c11
`define WIDTH_RESERVED_CODE 2'h3

// ****************************************
// reset values
// ****************************************
`define CONFIG_RESET 15'h0000
`define COUNT_RESET 16'h0000
`define MASK_RESET 32'h00000000
`define READ_RESET 32'h00000000

`endif

// File: src/dma_flags_pkg.sv
/*
 * Types shared by the DMA flag and channel configuration block.
 * Assumes the block has eight channels and a 32-bit register bus.
 */
package dma_flags_pkg;

  typedef enum logic [1:0] {
    bus_idle = 2'b00,
    bus_write = 2'b01,
    bus_read_wait = 2'b10,
    bus_read_done = 2'b11
  } bus_phase_type;

  typedef logic [14:0] config_word_type;

  typedef struct packed {
    bus_phase_type phase;
    logic [7:0] addr;
    config_word_type [7:0] config_reg;
    logic [31:0] irq_mask;
    logic [31:0] read_data;
    logic [7:0] grant;
    logic grant_valid;
    logic [1:0] width;
    logic width_is_source;
    logic mem_to_mem;
    logic width_reserved;
    logic irq;
  } ctrl_state_type;

  typedef struct packed {
    logic error;
    logic half;
    logic complete;
    logic [15:0] programmed;
    logic [15:0] remaining;
  } channel_state_type;

endpackage

// File: src/dma_channel_status.sv
/*
 * One channel's unit counter and its sticky event flags.
 * Assumes clear, load and event inputs come from logic on hclk.
 */
`timescale 1ns/1ps
`include "dma_flags_defs.svh"

module dma_channel_status (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enable,
  input wire logic count_load,
  input wire logic [15:0] count_value,
  input wire logic unit_done,
  input wire logic bus_error,
  input wire logic [3:0] clear,
  output logic [3:0] flags,
  output logic [15:0] remaining
);
  import dma_flags_pkg::*;

  channel_state_type state;
  channel_state_type next_state;
  logic moved;
  logic [15:0] after_move;
  logic clear_error;
  logic clear_half;
  logic clear_complete;
  logic hit_half;
  logic hit_complete;

  // ****************************************
  // counting and flags
  // ****************************************
  always_comb begin
    next_state = state;
    moved = enable && unit_done && (state.remaining != 16'h0000) && !count_load;
    after_move = state.remaining - 16'h0001;
    hit_half = moved && (after_move == (state.programmed >> 1));
    hit_complete = moved && (after_move == 16'h0000);
    clear_error = clear[`ERROR_BIT] || clear[`ALL_FLAGS_BIT];
    clear_half = clear[`HALF_BIT] || clear[`ALL_FLAGS_BIT];
    clear_complete = clear[`COMPLETE_BIT] || clear[`ALL_FLAGS_BIT];
    if (count_load) begin
      next_state.programmed = count_value;
      next_state.remaining = count_value;
    end else if (moved) begin
      next_state.remaining = after_move;
    end
    // a new event in the clearing cycle survives the clear
    next_state.error = (state.error && !clear_error) || (enable && bus_error);
    next_state.half = (state.half && !clear_half) || hit_half;
    next_state.complete = (state.complete && !clear_complete) || hit_complete;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flags[`ERROR_BIT] = state.error;
  assign flags[`HALF_BIT] = state.half;
  assign flags[`COMPLETE_BIT] = state.complete;
  assign flags[`ALL_FLAGS_BIT] = state.error || state.half || state.complete;
  assign remaining = state.remaining;

endmodule

// File: src/dma_priority_arbiter.sv
/*
 * Picks one pending channel by its two-bit priority level.
 * Assumes the caller registers the result; purely combinational here.
 */
`timescale 1ns/1ps

module dma_priority_arbiter (
  input wire logic [7:0] pending,
  input wire logic [15:0] priority_levels,
  output logic [7:0] grant,
  output logic grant_valid
);

  logic [2:0] best_index;
  logic [1:0] best_level;
  logic found;

  // ****************************************
  // search
  // ****************************************
  // strict greater-than keeps the lowest-numbered channel on a tie
  always_comb begin
    best_index = 3'h0;
    best_level = 2'h0;
    found = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (pending[i] && (!found || priority_levels[2*i +: 2] > best_level)) begin
        best_index = 3'(i);
        best_level = priority_levels[2*i +: 2];
        found = 1'b1;
      end
    end
    grant = found ? (8'h01 << best_index) : 8'h00;
    grant_valid = found;
  end

endmodule

// File: verification/dma_flag_config_properties.sv
/* Port checks for the DMA flag and channel configuration block.
   Assumes one clock domain and is bound to every dma_flag_config. */
`timescale 1ns/1ps
module dma_flag_config_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [7:0] channel_request,
  input wire logic [7:0] grant,
  input wire logic grant_valid,
  input wire logic [1:0] memory_side_width,
  input wire logic mem_to_mem_enable,
  input wire logic width_reserved,
  input wire logic irq
);
  logic take;
  logic wr_take;
  assign take = hsel && hready && htrans[1];
  assign wr_take = take && hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ********************
  // bus and outputs
  // ********************
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_rdata_hold: assert property ($past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  a_grant_onehot: assert property ($onehot0(grant) && grant_valid == (grant != 8'h00))
    else $error("grant not one-hot");
  a_width_code: assert property (width_reserved == (grant_valid && memory_side_width == 2'h3))
    else $error("reserved width flag wrong");
  a_grant_request: assert property (grant_valid && !mem_to_mem_enable |->
    (grant & $past(channel_request)) != 8'h00) else $error("grant without request");
  // irq only drops after a register write reached the flags or mask
  a_irq_fall: assert property ($fell(irq) |-> $past(wr_take, 3) ||
    $past(wr_take, 2)) else $error("irq fell without a write");
endmodule

bind dma_flag_config dma_flag_config_properties props (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .channel_request(channel_request),
  .grant(grant),
  .grant_valid(grant_valid),
  .memory_side_width(memory_side_width),
  .mem_to_mem_enable(mem_to_mem_enable),
  .width_reserved(width_reserved),
  .irq(irq)
);

// File: verification/dma_far_side.sv
/* Far side model: memories and peripherals that move units for the granted channel.
   Assumes the bench sets requests, the pace and whether transfers fail. */
`timescale 1ns/1ps
module dma_far_side (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [7:0] grant,
  input wire logic grant_valid,
  input wire logic [7:0] want,
  input wire logic fault,
  input wire logic slow,
  output logic [7:0] channel_request,
  output logic [7:0] unit_done,
  output logic [7:0] bus_error
);
  logic [1:0] pace;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pace <= 2'h0;
      channel_request <= 8'h00;
      unit_done <= 8'h00;
      bus_error <= 8'h00;
    end else begin
      pace <= pace + 2'h1;
      channel_request <= want;
      // slow pace moves one unit in four cycles
      unit_done <= (grant_valid && (!slow || pace == 2'h0)) ? grant : 8'h00;
      bus_error <= (grant_valid && fault) ? grant : 8'h00;
    end
  end
endmodule

// File: verification/dma_flag_config_tb.sv
/* Self-checking bench for the DMA flag and channel configuration block.
   Assumes the far side model serves whichever channel is granted. */
`timescale 1ns/1ps
module dma_flag_config_tb;
  logic hclk = 0, hresetn = 0, hwrite = 0, fault = 0, slow = 0, rd_phase = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 0, hwdata = 0, st = 0, cfg, g, hrdata;
  logic [7:0] want = 0, a, channel_request, unit_done, bus_error, grant;
  logic hreadyout, hresp, grant_valid, memory_side_is_source, mem_to_mem_enable;
  logic width_reserved, irq;
  logic [1:0] memory_side_width;
  logic [31:0] exp_q[$];
  int errors = 0, comparisons = 0, cycles = 0, seed = 32'he4fbfce6;
  always #2 hclk = ~hclk;
  dma_flag_config uut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .channel_request, .unit_done, .bus_error, .grant, .grant_valid, .memory_side_width,
    .memory_side_is_source, .mem_to_mem_enable, .width_reserved, .irq);
  dma_far_side far (.hclk, .hresetn, .grant, .grant_valid, .want, .fault, .slow,
    .channel_request, .unit_done, .bus_error);
  // ********************
  // bus tasks and scoreboard
  // ********************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ready is judged settled at the falling edge, then the rising edge is taken
  task automatic wt;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    haddr <= {24'h0, ad};
    hwrite <= w;
    htrans <= 2'h2;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, ad, 32'h0);
  endtask
  task automatic await(input logic v);
    @(negedge hclk);
    while (grant_valid !== v) @(negedge hclk);
  endtask
  always @(negedge hclk) begin
    cycles++;
    if (hreadyout === 1'b1) begin
      if (rd_phase) check(hrdata, exp_q.pop_front());
      rd_phase = htrans[1] && !hwrite;
    end
    if (cycles > 20000) begin
      errors++;
      summarize();
    end
  end
  // ********************
  // scenarios
  // ********************
  initial begin
    int c, n, w, p, d, k;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h00, 0);
    rd(8'h48, 0);
    bus(1'b1, 8'h4c, 32'hffffffff);
    rd(8'h4c, 0);
    bus(1'b1, 8'h08, 32'hffffffff);
    rd(8'h08, 32'h7c11);
    rd(8'h04, 0);
    bus(1'b1, 8'h08, 0);
    for (c = 0; c < 8; c++) begin
      a = 8'(4 * c);
      n = 2 + $unsigned($random(seed)) % 8;
      d = $unsigned($random(seed)) % 2;
      p = $unsigned($random(seed)) % 4;
      w = c % 4;
      k = c % 4;
      fault <= 1'(c % 2);
      slow <= 1'($random(seed));
      cfg = 32'h1 | d << 4 | w << 10 | p << 12;
      bus(1'b1, 8'h28 + a, n);
      bus(1'b1, 8'h08 + a, cfg);
      rd(8'h08 + a, cfg);
      want[c] <= 1'b1;
      await(1'b1);
      check({memory_side_is_source, memory_side_width, grant}, {d[0], w[1:0], 8'h1 << c});
      check(width_reserved, w == 3);
      await(1'b0);
      @(posedge hclk);
      want[c] <= 1'b0;
      g = {c[0], 3'h7};
      st = st | g << 4 * c;
      rd(8'h00, st);
      rd(8'h28 + a, 0);
      bus(1'b1, 8'h08 + a, cfg & 32'hfffffffe);
      bus(1'b1, 8'h04, 32'h1 << (4 * c + k));
      g = (k == 0) ? 32'h0 : g & ~(32'h1 << k);
      g[0] = |g[3:1];
      st = st & ~(32'hf << 4 * c) | g << 4 * c;
      rd(8'h00, st);
    end
    @(negedge hclk);
    check(irq, 1'b0);
    @(posedge hclk);
    bus(1'b1, 8'h48, 32'hffffffff);
    repeat (3) @(negedge hclk);
    check(irq, 1'b1);
    @(posedge hclk);
    bus(1'b1, 8'h04, 32'hffffffff);
    repeat (3) @(negedge hclk);
    check(irq, 1'b0);
    @(posedge hclk);
    rd(8'h00, 0);
    slow <= 1'b1;
    fault <= 1'b0;
    bus(1'b1, 8'h28, 32'h4);
    bus(1'b1, 8'h3c, 32'h3c);
    want <= 8'h20;
    bus(1'b1, 8'h1c, 32'h3001);
    bus(1'b1, 8'h08, 32'h4011);
    repeat (4) @(negedge hclk);
    check({mem_to_mem_enable, grant}, 32'h020);
    while (grant !== 8'h01) @(negedge hclk);
    check({mem_to_mem_enable, memory_side_is_source, grant}, 32'h301);
    await(1'b0);
    @(posedge hclk);
    rd(8'h00, 32'h00700007);
    summarize();
  end
endmodule
